// ### hdl/raw_pkg.sv
// Purpose: shared constants and carriers for the RAM arbiter with write protection
// Assumes: single clock REF_CLK, active-low asynchronous reset NRST
// Notes:   all offsets, widths and counts of the block live here
package raw_pkg;

  // ---------------------------------------------------------------
  // memory geometry
  // ---------------------------------------------------------------
  localparam int          RAM_BYTES    = 12288;                 // 12 kB
  localparam int          RAM_WORDS    = RAM_BYTES / 4;
  localparam int          WADDR_W      = 12;                    // word index width
  localparam int          BLK_BYTES    = 32;
  localparam int          BLK_COUNT    = RAM_BYTES / BLK_BYTES; // 384 blocks
  localparam int          BLK_SHIFT    = 5;                     // log2 of block bytes
  localparam int          BLK_IDX_W    = 9;
  localparam int          DMA_SRC      = 3;                     // DMA ports to the RAM
  localparam logic [31:0] RAM_BASE     = 32'h2000_0000;
  localparam logic [31:0] RAM_TOP      = 32'h2000_3000;         // first byte past RAM
  localparam logic [31:0] PERIPH_BASE  = 32'h4000_0000;
  localparam logic [1:0]  WAIT_FAST    = 2'h2;                  // wait states, fast clock

  // ---------------------------------------------------------------
  // access sizes and peripheral identifiers
  // ---------------------------------------------------------------
  localparam logic [1:0]  SZ_BYTE      = 2'h0;
  localparam logic [1:0]  SZ_HALF      = 2'h1;
  localparam logic [1:0]  SZ_WORD      = 2'h2;
  localparam logic [2:0]  ID_MAC       = 3'h0;
  localparam logic [2:0]  ID_SC_RX     = 3'h1;
  localparam logic [2:0]  ID_SC_TX     = 3'h2;
  localparam logic [2:0]  ID_NONE      = 3'h7;

  // system bus request seen by the RAM
  typedef struct packed {
    logic        req;    // access request
    logic        write;  // 1 write, 0 read
    logic        priv;   // privileged mode
    logic        fetch;  // instruction fetch
    logic [1:0]  size;   // byte, half, word
    logic [31:0] addr;   // byte address
    logic [31:0] wdata;  // write data, lane aligned
  } raw_bus_req_s;

  // direct DMA port request
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;  // full word
  } raw_dma_req_s;

  typedef enum logic [1:0] { ST_IDLE, ST_WAIT, ST_DONE } raw_bus_state_e;

endpackage : raw_pkg

// ### hdl/raw_lane_ram.sv
// Purpose: word-wide static RAM with byte lane enables and one read port
// Assumes: one access per clock, read data valid the cycle after
// Notes:   no reset on the array; contents are undefined at power-up
`timescale 1ns/1ps
module raw_lane_ram (
  input  wire logic                        clk,    // system clock
  input  wire logic                        en,     // access this cycle
  input  wire logic [3:0]                  we,     // byte lane write enables
  input  wire logic [raw_pkg::WADDR_W-1:0] waddr,  // word index
  input  wire logic [31:0]                 wdata,  // write data
  output logic      [31:0]                 rdata   // registered read data
);

  logic [31:0] mem [raw_pkg::RAM_WORDS];

  // ---------------------------------------------------------------
  // storage with per-lane writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (en) begin
      for (int i = 0; i < 4; i++) begin
        if (we[i]) begin
          mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
      rdata <= mem[waddr];
    end
  end

endmodule // raw_lane_ram

// ### hdl/raw_ram_arbiter.sv
// Purpose: 12 kB RAM shared by the system bus and three DMA masters, with block write protect
// Assumes: DMA masters hold req until granted; bus master holds request until ready
// Notes:   bus port gets one access per free cycle; DMA has the RAM first
//
// How it works
// - 12 kB RAM starting at 0x20000000
// - byte, half and word; fetch and data
// - zero waits, two in fast clock
// - serial port reads and writes concurrently; three channels
// - DMA reaches RAM directly, not bus
// - fixed priority: MAC, serial receive, transmit
// - one protect bit per 32-byte block
// - user write to protected block errors
// - privileged writes and all reads pass
// - control bit extends protection to DMA
// - protected DMA write raises management interrupt
// - capture fault address and peripheral id
// - peripherals from 0x40000000, word-aligned reads
`timescale 1ns/1ps
module raw_ram_arbiter (
  input  wire logic                          REF_CLK,      // system clock, 20 MHz
  input  wire logic                          NRST,         // async reset, active low
  input  wire logic                          FAST_CLK,     // higher cpu clock mode
  input  wire raw_pkg::raw_bus_req_s         BUS_REQ,      // system bus request
  output logic                               BUS_READY,    // access complete pulse
  output logic                               BUS_ERR,      // error response pulse
  output logic      [31:0]                   BUS_RDATA,    // read data with ready
  input  wire raw_pkg::raw_dma_req_s         DMA_MAC,      // radio mac port
  input  wire raw_pkg::raw_dma_req_s         DMA_SC_RX,    // serial receive port
  input  wire raw_pkg::raw_dma_req_s         DMA_SC_TX,    // serial transmit port
  output logic      [raw_pkg::DMA_SRC-1:0]   DMA_GNT,      // grant pulse per port
  output logic      [31:0]                   DMA_RDATA,    // read data, cycle after grant
  input  wire logic                          PROT_WR,      // protect map write strobe
  input  wire logic [raw_pkg::BLK_IDX_W-1:0] PROT_IDX,     // block index to update
  input  wire logic                          PROT_SET,     // new protect value
  output logic      [raw_pkg::BLK_COUNT-1:0] PROT_MAP,     // protect map readback
  input  wire logic                          DMA_PROT_EN,  // protect applies to dma
  input  wire logic                          FAULT_CLR,    // software clears interrupt
  output logic                               MGMT_IRQ,     // management interrupt
  output logic      [31:0]                   FAULT_ADDR,   // first faulting address
  output logic      [2:0]                    FAULT_ID,     // first faulting peripheral
  output logic                               PERIPH_SEL,   // bus address in register space
  output logic                               PERIPH_MISALIGN // register access not an aligned word
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic fast_s1_reg, fast_s2_reg;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      fast_s1_reg <= 1'b0;
      fast_s2_reg <= 1'b0;
    end else begin
      fast_s1_reg <= FAST_CLK;
      fast_s2_reg <= fast_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // dma arbitration
  // ---------------------------------------------------------------
  raw_pkg::raw_dma_req_s dma_win;
  logic [2:0]            dma_id;
  logic [raw_pkg::DMA_SRC-1:0] dma_gnt_next;
  always_comb begin
    dma_win      = '0;
    dma_id       = raw_pkg::ID_NONE;
    dma_gnt_next = '0;
    // a port whose grant is showing still holds the request just served
    if (DMA_MAC.req && !DMA_GNT[0]) begin
      dma_win = DMA_MAC;
      dma_id  = raw_pkg::ID_MAC;
      dma_gnt_next[0] = 1'b1;
    end else if (DMA_SC_RX.req && !DMA_GNT[1]) begin
      dma_win = DMA_SC_RX;
      dma_id  = raw_pkg::ID_SC_RX;
      dma_gnt_next[1] = 1'b1;
    end else if (DMA_SC_TX.req && !DMA_GNT[2]) begin
      dma_win = DMA_SC_TX;
      dma_id  = raw_pkg::ID_SC_TX;
      dma_gnt_next[2] = 1'b1;
    end
  end

  // serial rx and tx are independent ports, each may request any cycle

  // ---------------------------------------------------------------
  // address decode and protection
  // ---------------------------------------------------------------
  logic [31:0] dma_off, bus_off;
  logic        dma_prot_hit, bus_prot_hit, bus_in_ram, dma_in_ram;
  assign dma_off    = dma_win.addr - raw_pkg::RAM_BASE;
  assign bus_off    = BUS_REQ.addr - raw_pkg::RAM_BASE;
  assign bus_in_ram = (BUS_REQ.addr >= raw_pkg::RAM_BASE) &&
                      (BUS_REQ.addr < raw_pkg::RAM_TOP);
  assign dma_in_ram = (dma_win.addr >= raw_pkg::RAM_BASE) &&
                      (dma_win.addr < raw_pkg::RAM_TOP);
  assign dma_prot_hit = dma_in_ram &&
    PROT_MAP[dma_off[raw_pkg::BLK_SHIFT +: raw_pkg::BLK_IDX_W]];
  assign bus_prot_hit = bus_in_ram &&
    PROT_MAP[bus_off[raw_pkg::BLK_SHIFT +: raw_pkg::BLK_IDX_W]];

  logic dma_fault;
  assign dma_fault = dma_win.req && dma_win.write && DMA_PROT_EN && dma_prot_hit;

  // ---------------------------------------------------------------
  // bus access state machine
  // ---------------------------------------------------------------
  raw_pkg::raw_bus_state_e state_reg;
  logic [1:0]              wait_reg;
  logic                    bus_go, bus_deny, bus_live;
  // a request still up at its ready edge is the one just answered
  assign bus_live = BUS_REQ.req && !BUS_READY;
  assign bus_go   = bus_live && bus_in_ram && !dma_win.req &&
                    (state_reg == raw_pkg::ST_IDLE || state_reg == raw_pkg::ST_WAIT) &&
                    (wait_reg == 2'h0);
  assign bus_deny = BUS_REQ.write && !BUS_REQ.priv && bus_prot_hit;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= raw_pkg::ST_IDLE;
      wait_reg  <= 2'h0;
    end else begin
      case (state_reg)
        raw_pkg::ST_IDLE: begin
          // the idle cycle that takes the request is the first wait state
          if (bus_live && bus_in_ram && fast_s2_reg) begin
            state_reg <= raw_pkg::ST_WAIT;
            wait_reg  <= raw_pkg::WAIT_FAST - 2'h1;
          end else if (bus_live && (!bus_in_ram || bus_go)) begin
            state_reg <= raw_pkg::ST_DONE;
          end
        end
        raw_pkg::ST_WAIT: begin
          if (wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
          end else if (bus_go) begin
            state_reg <= raw_pkg::ST_DONE;
          end
        end
        default: state_reg <= raw_pkg::ST_IDLE;
      endcase
    end
  end

  // fast mode delays the ram slot by the wait count before access
  logic fast_hold;
  assign fast_hold = fast_s2_reg && state_reg == raw_pkg::ST_IDLE;

  // ---------------------------------------------------------------
  // ram port mux and lane enables
  // ---------------------------------------------------------------
  logic [3:0]                  bus_lanes, ram_we;
  logic                        ram_en;
  logic [raw_pkg::WADDR_W-1:0] ram_addr;
  logic [31:0]                 ram_wdata, ram_rdata;
  logic                        bus_fire;
  assign bus_fire = bus_go && !fast_hold;
  always_comb begin
    case (BUS_REQ.size)
      raw_pkg::SZ_BYTE: bus_lanes = 4'h1 << BUS_REQ.addr[1:0];
      raw_pkg::SZ_HALF: bus_lanes = BUS_REQ.addr[1] ? 4'hC : 4'h3;
      default:          bus_lanes = 4'hF;
    endcase
    ram_en    = 1'b0;
    ram_we    = 4'h0;
    ram_addr  = '0;
    ram_wdata = dma_win.wdata;
    if (dma_win.req && dma_in_ram) begin
      ram_en   = 1'b1;
      ram_addr = dma_off[2 +: raw_pkg::WADDR_W];
      ram_we   = (dma_win.write && !dma_fault) ? 4'hF : 4'h0;
    end else if (bus_fire) begin
      ram_en    = 1'b1;
      ram_addr  = bus_off[2 +: raw_pkg::WADDR_W];
      ram_wdata = BUS_REQ.wdata;
      ram_we    = (BUS_REQ.write && !bus_deny) ? bus_lanes : 4'h0;
    end
  end

  raw_lane_ram u_ram (
    .clk   (REF_CLK),
    .en    (ram_en),
    .we    (ram_we),
    .waddr (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  // ---------------------------------------------------------------
  // bus answer registers
  // ---------------------------------------------------------------
  logic ans_pend_reg, ans_err_reg, ans_rd_reg, dma_rd_reg;
  logic addr_miss;
  assign addr_miss = bus_live && !bus_in_ram && state_reg == raw_pkg::ST_IDLE;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ans_pend_reg <= 1'b0;
      ans_err_reg  <= 1'b0;
      ans_rd_reg   <= 1'b0;
      dma_rd_reg   <= 1'b0;
      BUS_READY    <= 1'b0;
      BUS_ERR      <= 1'b0;
      BUS_RDATA    <= 32'h0000_0000;
      DMA_GNT      <= '0;
      DMA_RDATA    <= 32'h0000_0000;
    end else begin
      ans_pend_reg <= bus_fire || addr_miss;
      ans_err_reg  <= (bus_fire && BUS_REQ.write && bus_deny);
      ans_rd_reg   <= bus_fire && !BUS_REQ.write;
      dma_rd_reg   <= dma_win.req && !dma_win.write;
      DMA_GNT      <= dma_gnt_next;
      BUS_READY    <= ans_pend_reg;
      BUS_ERR      <= ans_err_reg;
      if (ans_rd_reg) begin
        BUS_RDATA <= ram_rdata;
      end
      if (dma_rd_reg) begin
        DMA_RDATA <= ram_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // protection map
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PROT_MAP <= '0;
    end else if (PROT_WR && PROT_IDX < raw_pkg::BLK_IDX_W'(raw_pkg::BLK_COUNT)) begin
      PROT_MAP[PROT_IDX] <= PROT_SET;
    end
  end

  // ---------------------------------------------------------------
  // dma fault capture
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      MGMT_IRQ   <= 1'b0;
      FAULT_ADDR <= 32'h0000_0000;
      FAULT_ID   <= raw_pkg::ID_NONE;
    end else if (dma_fault && !MGMT_IRQ) begin
      MGMT_IRQ   <= 1'b1;
      FAULT_ADDR <= dma_win.addr;
      FAULT_ID   <= dma_id;
    end else if (FAULT_CLR && !dma_fault) begin                    // set wins over clear
      MGMT_IRQ   <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register space decode
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PERIPH_SEL      <= 1'b0;
      PERIPH_MISALIGN <= 1'b0;
    end else begin
      PERIPH_SEL      <= BUS_REQ.req && BUS_REQ.addr >= raw_pkg::PERIPH_BASE;
      PERIPH_MISALIGN <= BUS_REQ.req && BUS_REQ.addr >= raw_pkg::PERIPH_BASE &&
                         (BUS_REQ.addr[1:0] != 2'h0 ||
                          BUS_REQ.size != raw_pkg::SZ_WORD);
    end
  end

endmodule // raw_ram_arbiter

// ### test/raw_dma_master.sv
// Purpose: behavioural DMA master for one arbiter port
// Assumes: the arbiter grants one cycle after it takes a request
// Notes:   released address and data lines show inverted values
`timescale 1ns/1ps
module raw_dma_master (
  input  wire logic             clk,     // system clock
  input  wire logic             nrst,    // reset, active low
  input  wire logic             start,   // begin a transfer
  input  wire logic             wr,      // write when high
  input  wire logic [31:0]      addr,    // byte address of the word
  input  wire logic [31:0]      wdata,   // write word
  input  wire logic             gnt,     // grant pulse
  input  wire logic [31:0]      rdata,   // read data
  output raw_pkg::raw_dma_req_s req,     // port request
  output logic      [31:0]      rd_word  // word read
);
  raw_pkg::raw_dma_req_s req_reg;
  logic                  got_reg;
  assign req = req_reg;
  // hold the request until granted, then scramble the released lines
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) req_reg <= '0;
    else if (start) req_reg <= '{1'h1, wr, addr, wdata};
    else if (gnt && req_reg.req) req_reg <= '{1'h0, ~req_reg.write, ~req_reg.addr, ~req_reg.wdata};
  end
  // take the read word one cycle after the grant
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) got_reg <= 1'h0;
    else got_reg <= gnt && req_reg.req;
  end
  always_ff @(posedge clk) begin
    if (got_reg) rd_word <= rdata;
  end
endmodule // raw_dma_master

// ### test/raw_ram_arbiter_asserts.sv
// Purpose: concurrent checks on the RAM arbiter ports
// Assumes: one clock, NRST low resets everything but the RAM array and its read data register
// Notes:   bound to every raw_ram_arbiter instance
`timescale 1ns/1ps
module raw_ram_arbiter_asserts (
  input wire logic                          REF_CLK,    // clock
  input wire logic                          NRST,       // reset
  input wire raw_pkg::raw_bus_req_s         BUS_REQ,    // bus request
  input wire logic                          BUS_READY,  // bus done
  input wire logic                          BUS_ERR,    // bus error
  input wire raw_pkg::raw_dma_req_s         DMA_MAC,    // mac port
  input wire raw_pkg::raw_dma_req_s         DMA_SC_RX,  // receive port
  input wire raw_pkg::raw_dma_req_s         DMA_SC_TX,  // transmit port
  input wire logic [raw_pkg::DMA_SRC-1:0]   DMA_GNT,    // grants
  input wire logic                          PROT_WR,    // map strobe
  input wire logic [raw_pkg::BLK_IDX_W-1:0] PROT_IDX,   // map index
  input wire logic                          PROT_SET,   // map value
  input wire logic [raw_pkg::BLK_COUNT-1:0] PROT_MAP,   // map
  input wire logic                          FAULT_CLR,  // irq clear
  input wire logic                          MGMT_IRQ,   // irq
  input wire logic [31:0]                   FAULT_ADDR, // fault address
  input wire logic [2:0]                    FAULT_ID,   // fault source
  input wire logic                          PERIPH_SEL  // register space
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // a request whose grant is showing has been served and waits to drop
  logic mac_live, rx_live, tx_live;
  assign mac_live = DMA_MAC.req && !DMA_GNT[0];
  assign rx_live  = DMA_SC_RX.req && !DMA_GNT[1];
  assign tx_live  = DMA_SC_TX.req && !DMA_GNT[2];
  // grants follow fixed priority one cycle after the requests
  AST_GNT_MAC: assert property ($past(mac_live) |-> DMA_GNT == 3'h1)
    else $error("mac not granted alone");
  AST_GNT_RX: assert property ($past(rx_live && !mac_live) |-> DMA_GNT == 3'h2)
    else $error("receive not granted");
  AST_GNT_TX: assert property ($past(tx_live && !rx_live && !mac_live)
    |-> DMA_GNT == 3'h4) else $error("transmit not granted");
  AST_GNT_NONE: assert property ($past(!mac_live && !rx_live && !tx_live)
    |-> DMA_GNT == 3'h0) else $error("grant without request");
  // bus answers
  AST_ERR_READY: assert property (BUS_ERR |-> BUS_READY) else $error("error without ready");
  AST_ERR_USER: assert property (BUS_ERR |-> BUS_REQ.write && !BUS_REQ.priv)
    else $error("error on read or privileged write");
  AST_READY_PULSE: assert property (BUS_READY |=> !BUS_READY) else $error("ready too long");
  AST_PERIPH: assert property ($past(BUS_REQ.req && BUS_REQ.addr >= raw_pkg::PERIPH_BASE)
    |-> PERIPH_SEL) else $error("register space not flagged");
  // protection map and fault capture
  AST_MAP: assert property (PROT_WR |=> PROT_MAP[$past(PROT_IDX)] == $past(PROT_SET))
    else $error("map bit not updated");
  AST_IRQ_HOLD: assert property (MGMT_IRQ && !FAULT_CLR |=> MGMT_IRQ)
    else $error("irq dropped without clear");
  AST_FAULT_HOLD: assert property (MGMT_IRQ && $past(MGMT_IRQ) |-> $stable(FAULT_ADDR)
    && $stable(FAULT_ID)) else $error("held fault overwritten");
  AST_IRQ_ID: assert property ($rose(MGMT_IRQ) |-> FAULT_ID != raw_pkg::ID_NONE)
    else $error("irq without source");
endmodule // raw_ram_arbiter_asserts
bind raw_ram_arbiter raw_ram_arbiter_asserts u_chk (.REF_CLK(REF_CLK), .NRST(NRST),
  .BUS_REQ(BUS_REQ), .BUS_READY(BUS_READY), .BUS_ERR(BUS_ERR), .DMA_MAC(DMA_MAC),
  .DMA_SC_RX(DMA_SC_RX), .DMA_SC_TX(DMA_SC_TX), .DMA_GNT(DMA_GNT), .PROT_WR(PROT_WR),
  .PROT_IDX(PROT_IDX), .PROT_SET(PROT_SET), .PROT_MAP(PROT_MAP), .FAULT_CLR(FAULT_CLR),
  .MGMT_IRQ(MGMT_IRQ), .FAULT_ADDR(FAULT_ADDR), .FAULT_ID(FAULT_ID), .PERIPH_SEL(PERIPH_SEL));

// ### test/test_raw_ram_arbiter.sv
// Purpose: self-checking bench for the RAM arbiter with block write protect
// Assumes: DMA ports driven by raw_dma_master, bus driven by tasks here
// Notes:   bus request is released at the edge after ready is seen
`timescale 1ns/1ps
module test_raw_ram_arbiter;
  localparam logic [31:0] B = raw_pkg::RAM_BASE;
  localparam logic [1:0]  WD = raw_pkg::SZ_WORD;
  logic                          REF_CLK, NRST, FAST_CLK, PROT_WR, PROT_SET, DMA_PROT_EN, FAULT_CLR;
  logic                          BUS_READY, BUS_ERR, MGMT_IRQ, PERIPH_SEL, PERIPH_MISALIGN, er, ms;
  logic [raw_pkg::BLK_IDX_W-1:0] PROT_IDX;
  logic [raw_pkg::BLK_COUNT-1:0] PROT_MAP;
  logic [31:0]                   BUS_RDATA, DMA_RDATA, FAULT_ADDR, rd;
  logic [2:0]                    DMA_GNT, FAULT_ID, d_wr, d_go;
  logic [31:0]                   d_addr [3], d_wdata [3], d_rd [3];
  raw_pkg::raw_bus_req_s         BUS_REQ;
  raw_pkg::raw_dma_req_s         dreq [3];
  int                            miscompares, n_compared, lat, fg [3];
  raw_ram_arbiter uut (.REF_CLK(REF_CLK), .NRST(NRST), .FAST_CLK(FAST_CLK), .BUS_REQ(BUS_REQ),
    .BUS_READY(BUS_READY), .BUS_ERR(BUS_ERR), .BUS_RDATA(BUS_RDATA), .DMA_MAC(dreq[0]),
    .DMA_SC_RX(dreq[1]), .DMA_SC_TX(dreq[2]), .DMA_GNT(DMA_GNT), .DMA_RDATA(DMA_RDATA),
    .PROT_WR(PROT_WR), .PROT_IDX(PROT_IDX), .PROT_SET(PROT_SET), .PROT_MAP(PROT_MAP),
    .DMA_PROT_EN(DMA_PROT_EN), .FAULT_CLR(FAULT_CLR), .MGMT_IRQ(MGMT_IRQ), .FAULT_ADDR(FAULT_ADDR),
    .FAULT_ID(FAULT_ID), .PERIPH_SEL(PERIPH_SEL), .PERIPH_MISALIGN(PERIPH_MISALIGN));
  for (genvar i = 0; i < 3; i++) begin : g_dm
    raw_dma_master u_dm (.clk(REF_CLK), .nrst(NRST), .start(d_go[i]), .wr(d_wr[i]),
      .addr(d_addr[i]), .wdata(d_wdata[i]), .gnt(DMA_GNT[i]), .rdata(DMA_RDATA),
      .req(dreq[i]), .rd_word(d_rd[i]));
  end
  // 50 ns clock
  initial begin
    REF_CLK = 1'h0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one bus access: {write, priv, fetch}, size, address, lane-aligned data
  task automatic bus(input logic [2:0] wpf, input logic [1:0] sz, input logic [31:0] a, d);
    @(posedge REF_CLK);
    BUS_REQ <= '{1'h1, wpf[2], wpf[1], wpf[0], sz, a, d};
    lat = -1;
    ms = 1'h0;
    do begin
      @(negedge REF_CLK);
      lat++;
      ms |= PERIPH_MISALIGN;
    end while (BUS_READY !== 1'h1 && lat < 40);
    if (lat >= 40) begin miscompares++; close_out(); end
    rd = BUS_RDATA;
    er = BUS_ERR;
    @(posedge REF_CLK);
    BUS_REQ <= '{1'h0, ~wpf[2], ~wpf[1], ~wpf[0], ~sz, ~a, ~d};
  endtask
  // start the DMA masters in mask m, note the cycle of each first grant
  task automatic dgo(input logic [2:0] m);
    int n;
    @(posedge REF_CLK);
    d_go <= m;
    @(posedge REF_CLK);
    d_go <= 3'h0;
    fg = '{-1, -1, -1};
    for (n = 0; n < 30 && (n < 4 || dreq[0].req || dreq[1].req || dreq[2].req); n++) begin
      @(negedge REF_CLK);
      for (int k = 0; k < 3; k++) if (DMA_GNT[k] === 1'h1 && fg[k] < 0) fg[k] = n;
    end
    if (n >= 30) begin miscompares++; close_out(); end
    repeat (2) @(negedge REF_CLK);
  endtask
  task automatic t_ram();
    check({BUS_READY, MGMT_IRQ, DMA_GNT, FAULT_ID, |PROT_MAP}, 32'hE);
    bus(3'h4, WD, B, 32'h1122_3344);
    check(lat, 32'h2);
    bus(3'h4, raw_pkg::SZ_BYTE, B + 32'h1, 32'h0000_AB00);
    bus(3'h4, raw_pkg::SZ_HALF, B + 32'h2, 32'hCDEF_0000);
    bus(3'h1, WD, B, 32'h0);
    check(rd, 32'hCDEF_AB44);
    bus(3'h4, WD, raw_pkg::RAM_TOP - 32'h4, 32'h5A5A_A5A5);
    bus(3'h0, WD, raw_pkg::RAM_TOP - 32'h4, 32'h0);
    check(rd, 32'h5A5A_A5A5);
    @(posedge REF_CLK);
    FAST_CLK <= 1'h1;
    repeat (4) @(posedge REF_CLK);
    bus(3'h0, WD, B, 32'h0);
    check(lat, 32'h4);
    check(rd, 32'hCDEF_AB44);
    @(posedge REF_CLK);
    FAST_CLK <= 1'h0;
    repeat (4) @(posedge REF_CLK);
    $display("done: ram and wait states");
  endtask
  task automatic t_prot();
    @(posedge REF_CLK);
    PROT_WR <= 1'h1;
    PROT_IDX <= 9'h2;
    PROT_SET <= 1'h1;
    @(posedge REF_CLK);
    PROT_WR <= 1'h0;
    @(negedge REF_CLK);
    check(PROT_MAP[3:1], 3'h2);
    bus(3'h6, WD, B + 32'h5C, 32'h600D_0001);
    check(er, 1'h0);
    bus(3'h4, WD, B + 32'h5C, 32'hBAD0_0001);
    check(er, 1'h1);
    bus(3'h4, raw_pkg::SZ_BYTE, B + 32'h5F, 32'hEE00_0000);
    check(er, 1'h1);
    bus(3'h1, WD, B + 32'h5C, 32'h0);
    check({er, rd}, {1'h0, 32'h600D_0001});
    bus(3'h4, WD, B + 32'h60, 32'h0000_0060);
    check(er, 1'h0);
    $display("done: protection map");
  endtask
  task automatic t_dma();
    bus(3'h6, WD, B + 32'h80, 32'h0DA7_A000);
    @(posedge REF_CLK);
    d_wr <= 3'h2;
    d_addr <= '{B + 32'h80, B + 32'h48, B + 32'h80};
    d_wdata <= '{32'h0, 32'h1234_5678, 32'h0};
    dgo(3'h7);
    check(fg[0] >= 0 && fg[0] < fg[1] && fg[1] < fg[2], 1'h1);
    check(d_rd[0], 32'h0DA7_A000);
    check(d_rd[2], 32'h0DA7_A000);
    bus(3'h0, WD, B + 32'h48, 32'h0);
    check({MGMT_IRQ, rd}, {1'h0, 32'h1234_5678});
    $display("done: dma priority");
  endtask
  task automatic t_fault();
    @(posedge REF_CLK);
    DMA_PROT_EN <= 1'h1;
    d_wr <= 3'h3;
    d_addr <= '{B + 32'h5C, B + 32'h4C, 32'h0};
    d_wdata <= '{32'hAAAA_0000, 32'hBBBB_0000, 32'h0};
    dgo(3'h2);
    check({MGMT_IRQ, FAULT_ID}, {1'h1, raw_pkg::ID_SC_RX});
    check(FAULT_ADDR, B + 32'h4C);
    dgo(3'h1);
    check({FAULT_ADDR, FAULT_ID}, {B + 32'h4C, raw_pkg::ID_SC_RX});
    bus(3'h0, WD, B + 32'h5C, 32'h0);
    check(rd, 32'h600D_0001);
    @(posedge REF_CLK);
    FAULT_CLR <= 1'h1;
    @(posedge REF_CLK);
    FAULT_CLR <= 1'h0;
    @(negedge REF_CLK);
    check(MGMT_IRQ, 1'h0);
    $display("done: dma fault capture");
  endtask
  task automatic t_periph();
    bus(3'h0, WD, raw_pkg::PERIPH_BASE, 32'h0);
    check({er, ms}, 2'h0);
    bus(3'h0, raw_pkg::SZ_BYTE, raw_pkg::PERIPH_BASE + 32'h1, 32'h0);
    check(ms, 1'h1);
    $display("done: register space");
  endtask
  // reset for ten cycles, then run the scenarios
  initial begin
    NRST = 1'h0;
    {FAST_CLK, PROT_WR, PROT_SET, DMA_PROT_EN, FAULT_CLR, PROT_IDX, d_go, d_wr} = '0;
    BUS_REQ = '0;
    d_addr = '{default: 32'h0};
    d_wdata = '{default: 32'h0};
    miscompares = 0;
    n_compared = 0;
    repeat (10) @(posedge REF_CLK);
    NRST <= 1'h1;
    @(negedge REF_CLK);
    t_ram();
    t_prot();
    t_dma();
    t_fault();
    t_periph();
    close_out();
  end
endmodule // test_raw_ram_arbiter
